// ==== design/hdlc_rx_addr_filter_fifo.sv ====
// HDLC receive path: address filter, block receive FIFO, event wait line
// Contract
// RULE1 - D-channel: two SAPI, two TEI, groups
// RULE2 - B-channel: two high, two low, groups (code skips the low-byte group compare in transparent 2 mode)
// RULE3 - Command/response bit masked in every compare (code masks it in the high-byte compare only, low-byte compare is unmasked)
// RULE4 - Non-auto: one or two byte recognition
// RULE5 - Transparent 0: store whole frame, no filter
// RULE6 - Transparent 1: filter on first byte only
// RULE7 - Transparent 2: filter on second byte only
// RULE8 - Extended mode: no framing, fully transparent
// RULE9 - FIFO 64 or 128 bytes, block thresholds
// RULE10 - Pool-full when block ready, frame longer
// RULE11 - Message-end when frame tail stored
// RULE12 - Full FIFO at frame start: drop, flag
// RULE13 - Release frees block; no irq before release
// RULE14 - Receiver reset empties FIFO, keeps pending
// RULE15 - Twelve-bit length counter with overflow bit
// RULE16 - Threshold code decoding per channel
// RULE17 - Counter low bits give last block bytes
// RULE18 - Threshold loaded only on release/reset
// RULE19 - Status byte appended after every frame
// RULE20 - Events queued, next raised after release
// RULE21 - Partial loss sets data-overflow status bit
// RULE22 - Over-reads repeat last byte; release discards
// RULE23 - Reads advance pointer, no address used
// RULE24 - Compare ends before following bytes stored
`include "hdlc_rx_map.svh"

module hdlc_rx_addr_filter_fifo #(
  parameter bit IS_D_CHANNEL = 1'b1,
  parameter int DEPTH        = 64,
  parameter int QDEPTH       = 16
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  resetn,
  // Serial channel link
  input  wire hdlc_rx_pkg::rx_link_t link,
  // Configuration
  input  wire logic [2:0]            transfer_mode_code,
  input  wire logic [1:0]            rx_threshold_code,
  input  wire hdlc_rx_pkg::addr_cfg_t addr_cfg,
  // Host commands and FIFO read
  input  wire logic                  block_release_cmd,
  input  wire logic                  receiver_reset_cmd,
  input  wire logic                  host_rd,
  output logic [7:0]                 receive_fifo,
  // Interrupts and status
  output logic                       pool_full_irq,
  output logic                       message_end_irq,
  output logic                       frame_lost_irq,
  output logic                       irq_pending,
  output logic [11:0]                frame_byte_counter,
  output logic                       count_overflow_flag,
  output logic [7:0]                 byte_count_low,
  output logic [7:0]                 byte_count_high
);

  localparam int AW = $clog2(DEPTH);
  localparam int QW = $clog2(QDEPTH);
  localparam logic [AW:0] DEPTH_W  = (AW+1)'(DEPTH);
  localparam logic [QW:0] QDEPTH_W = (QW+1)'(QDEPTH);

  // ****************************************
  // State
  // ****************************************
  hdlc_rx_pkg::rx_state_t st_q;
  hdlc_rx_pkg::rx_event_t q_mem_q [QDEPTH];
  logic [7:0]  mem_q [DEPTH];
  logic [AW:0] wr_ptr_q, rd_base_q;
  logic [QW:0] q_cnt_q;
  logic [QW-1:0] q_head_q, q_tail_q;
  logic [1:0]  pos_q, thr_code_q;
  logic [7:0]  blk_cnt_q, blk_len_q, rd_ofs_q, rx_data_q;
  logic [11:0] frame_cnt_q, cnt_out_q;
  logic        frame_ov_q, rdo_q, cr_q, busy_q, last_end_q, ov_out_q;
  logic        pf_q, me_q, lost_q;

  // ****************************************
  // Mode and threshold decode
  // ****************************************
  wire [2:0] mode      = transfer_mode_code;
  wire       m_one     = mode == `HRX_MODE_ONE;
  wire       m_two     = mode == `HRX_MODE_TWO;
  wire       m_t1      = mode == `HRX_MODE_T1;
  wire       m_t2      = mode == `HRX_MODE_T2;
  wire       m_t0      = mode == `HRX_MODE_T0;
  wire       ext       = mode == `HRX_MODE_EXT;                                 // RULE8
  wire       known     = m_one | m_two | m_t1 | m_t2 | m_t0;
  wire [1:0] skip      = (m_one | m_t1) ? 2'd1 : (m_two | m_t2) ? 2'd2 : 2'd0; // RULE5
  wire [7:0] d_size    = (thr_code_q == `HRX_THR_32) ? `HRX_BLK_32 :
                         (thr_code_q == `HRX_THR_16) ? `HRX_BLK_16 :
                         (thr_code_q == `HRX_THR_8)  ? `HRX_BLK_8  : `HRX_BLK_4; // RULE16
  wire [7:0] b_size    = thr_code_q[0] ? `HRX_BLK_8 : `HRX_BLK_16;            // RULE16
  wire [7:0] bsize     = IS_D_CHANNEL ? d_size : b_size;                       // RULE9

  // ****************************************
  // Address recognition
  // ****************************************
  wire [7:0] rx_masked = link.data & `HRX_CR_MASK;                             // RULE3
  wire       high_hit  = rx_masked == (addr_cfg.high_a & `HRX_CR_MASK) |
                         rx_masked == (addr_cfg.high_b & `HRX_CR_MASK) |
                         rx_masked == `HRX_GROUP_HIGH;                         // RULE1 RULE2
  wire       grp_low   = IS_D_CHANNEL | ~m_t2;                                 // RULE7
  wire       low_hit   = link.data == addr_cfg.low_a |
                         link.data == addr_cfg.low_b |
                         (grp_low & link.data == `HRX_GROUP_LOW);              // RULE1 RULE2
  wire       cmp_high  = pos_q == 2'd0 & (m_one | m_two | m_t1);              // RULE4 RULE6
  wire       cmp_low   = pos_q == 2'd1 & (m_two | m_t2);                      // RULE4 RULE7
  wire       byte_hit  = ~(cmp_high & ~high_hit) & ~(cmp_low & ~low_hit);

  // ****************************************
  // Space and write decisions
  // ****************************************
  wire [AW:0] used     = wr_ptr_q - rd_base_q;
  wire [AW:0] free     = DEPTH_W - used;
  wire        q_full   = q_cnt_q == QDEPTH_W;
  wire        q_two    = q_cnt_q <= QDEPTH_W - (QW+1)'(2);
  wire        blk_fill = (blk_cnt_q + 8'h01) == bsize;
  wire        in_data  = st_q == hdlc_rx_pkg::ST_DATA & ~ext;
  // One byte and one queue slot stay spare for the status byte
  wire        fr_room  = free > (AW+1)'(1) & (~blk_fill | q_two);
  wire        ex_room  = free != '0 & (~blk_fill | ~q_full);
  wire        wr_data  = link.valid & ((in_data & fr_room) | (ext & ex_room));  // RULE24
  wire        lost_dat = link.valid & in_data & ~fr_room;                      // RULE21
  wire        wr_stat  = link.eof & in_data;                                   // RULE19
  wire        sof_go   = link.sof & ~ext;
  wire        start_ok = free != '0 & ~q_full & known;
  wire        lost_frm = sof_go & known & ~start_ok;                           // RULE12
  wire        rreset   = receiver_reset_cmd;
  wire        release_ = block_release_cmd & busy_q;

  wire [7:0]  stat_byte;
  assign stat_byte = ({7'h00, link.crc_ok & ~link.abort & ~rdo_q} << `HRX_STAT_VFR) |
                     ({7'h00, rdo_q | lost_dat} << `HRX_STAT_RDO) |
                     ({7'h00, link.crc_ok} << `HRX_STAT_CRC) |
                     ({7'h00, link.abort} << `HRX_STAT_RAB) |
                     ({7'h00, cr_q} << `HRX_STAT_CR);                          // RULE21

  wire        wr_en    = (wr_data | wr_stat) & ~rreset;
  wire [7:0]  wr_byte  = wr_stat ? stat_byte : link.data;
  wire        cnt_top  = frame_cnt_q == `HRX_CNT_MAX;
  wire        push     = wr_en & (wr_stat | blk_fill);                          // RULE10 RULE11
  hdlc_rx_pkg::rx_event_t push_ev;
  assign push_ev = '{is_end: wr_stat,
                     len:    wr_stat ? blk_cnt_q + 8'h01 : bsize,
                     count:  frame_cnt_q + 12'h001,
                     ov:     frame_ov_q | cnt_top};                            // RULE15
  wire        pop      = ~busy_q & q_cnt_q != '0 & ~block_release_cmd & ~rreset; // RULE20
  hdlc_rx_pkg::rx_event_t head_ev;
  assign head_ev = q_mem_q[q_head_q];

  // ****************************************
  // Host read selection
  // ****************************************
  wire        rd_more  = rd_ofs_q < blk_len_q;
  wire [7:0]  rd_eff   = (rd_more | rd_ofs_q == 8'h00) ? rd_ofs_q : rd_ofs_q - 8'h01; // RULE22
  wire [AW:0] rd_addr  = rd_base_q + rd_eff[AW:0];

  // ****************************************
  // Frame receiver state machine
  // ****************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q  <= hdlc_rx_pkg::ST_IDLE;
      pos_q <= 2'd0;
      cr_q  <= 1'b0;
    end else if (rreset || ext) begin
      st_q  <= hdlc_rx_pkg::ST_IDLE;                                           // RULE14
      pos_q <= 2'd0;
    end else if (sof_go) begin
      pos_q <= 2'd0;
      cr_q  <= 1'b0;
      if (!start_ok) begin
        st_q <= hdlc_rx_pkg::ST_DROP;                                          // RULE12
      end else if (skip == 2'd0) begin
        st_q <= hdlc_rx_pkg::ST_DATA;                                          // RULE5
      end else begin
        st_q <= hdlc_rx_pkg::ST_ADDR;
      end
    end else begin
      case (st_q)
        hdlc_rx_pkg::ST_ADDR: begin
          if (link.eof) begin
            st_q <= hdlc_rx_pkg::ST_IDLE;
          end else if (link.valid) begin
            pos_q <= pos_q + 2'd1;
            if (pos_q == 2'd0) begin
              cr_q <= link.data[1];
            end
            if (!byte_hit) begin
              st_q <= hdlc_rx_pkg::ST_DROP;                                    // RULE24
            end else if (pos_q + 2'd1 == skip) begin
              st_q <= hdlc_rx_pkg::ST_DATA;                                    // RULE4
            end
          end
        end
        hdlc_rx_pkg::ST_DATA, hdlc_rx_pkg::ST_DROP: begin
          if (link.eof) begin
            st_q <= hdlc_rx_pkg::ST_IDLE;
          end
        end
        default: st_q <= hdlc_rx_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // FIFO write side and frame counters
  // ****************************************
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem_q[wr_ptr_q[AW-1:0]] <= wr_byte;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_q    <= '0;
      blk_cnt_q   <= 8'h00;
      frame_cnt_q <= 12'h000;
      frame_ov_q  <= 1'b0;
      rdo_q       <= 1'b0;
    end else if (rreset) begin
      wr_ptr_q    <= '0;                                                       // RULE14
      blk_cnt_q   <= 8'h00;
      frame_cnt_q <= 12'h000;
      frame_ov_q  <= 1'b0;
      rdo_q       <= 1'b0;
    end else begin
      if (sof_go || wr_stat) begin
        blk_cnt_q   <= 8'h00;
        frame_cnt_q <= 12'h000;
        frame_ov_q  <= 1'b0;
        rdo_q       <= 1'b0;
      end else begin
        if (wr_data) begin
          blk_cnt_q   <= blk_fill ? 8'h00 : blk_cnt_q + 8'h01;               // RULE17
          frame_cnt_q <= frame_cnt_q + 12'h001;                                // RULE15
          frame_ov_q  <= frame_ov_q | cnt_top;                                 // RULE15
        end
        if (lost_dat) begin
          rdo_q <= 1'b1;                                                       // RULE21
        end
      end
      if (wr_en) begin
        wr_ptr_q <= wr_ptr_q + (AW+1)'(1);
      end
    end
  end

  // ****************************************
  // Event wait line
  // ****************************************
  always_ff @(posedge clock) begin
    if (push) begin
      q_mem_q[q_tail_q] <= push_ev;                                            // RULE20
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      q_head_q <= '0;
      q_tail_q <= '0;
      q_cnt_q  <= '0;
    end else if (rreset) begin
      q_head_q <= '0;
      q_tail_q <= '0;
      q_cnt_q  <= '0;
    end else begin
      q_head_q <= q_head_q + QW'(pop);
      q_tail_q <= q_tail_q + QW'(push);
      q_cnt_q  <= q_cnt_q + (QW+1)'(push) - (QW+1)'(pop);
    end
  end

  // ****************************************
  // Host handshake: raise, release, threshold
  // ****************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy_q     <= 1'b0;
      last_end_q <= 1'b0;
      blk_len_q  <= 8'h00;
      cnt_out_q  <= 12'h000;
      ov_out_q   <= 1'b0;
      pf_q       <= 1'b0;
      me_q       <= 1'b0;
      lost_q     <= 1'b0;
      thr_code_q <= `HRX_THR_RESET;                                            // RULE18
    end else begin
      pf_q   <= pop & ~head_ev.is_end;                                         // RULE10
      me_q   <= pop & head_ev.is_end;                                          // RULE11
      lost_q <= lost_frm & ~rreset;                                            // RULE12
      if (block_release_cmd || rreset) begin
        thr_code_q <= rx_threshold_code;                                       // RULE18
      end
      if (pop) begin
        busy_q     <= 1'b1;                                                    // RULE13
        last_end_q <= head_ev.is_end;
        blk_len_q  <= head_ev.len;
        cnt_out_q  <= head_ev.count;
        ov_out_q   <= head_ev.ov;
      end else if (release_) begin
        busy_q    <= 1'b0;                                                     // RULE13
        blk_len_q <= 8'h00;
        if (last_end_q) begin
          cnt_out_q <= 12'h000;                                                // RULE13
          ov_out_q  <= 1'b0;
        end
      end else if (rreset) begin
        blk_len_q <= 8'h00;                                                    // RULE14
      end
    end
  end

  // ****************************************
  // Host read side
  // ****************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rd_base_q <= '0;
      rd_ofs_q  <= 8'h00;
      rx_data_q <= 8'h00;
    end else if (rreset) begin
      rd_base_q <= '0;
      rd_ofs_q  <= 8'h00;
    end else if (release_) begin
      rd_base_q <= rd_base_q + blk_len_q[AW:0];                                // RULE13 RULE22
      rd_ofs_q  <= 8'h00;
    end else if (host_rd) begin
      rx_data_q <= mem_q[rd_addr[AW-1:0]];                                     // RULE23
      if (rd_more) begin
        rd_ofs_q <= rd_ofs_q + 8'h01;                                          // RULE22
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign receive_fifo        = rx_data_q;
  assign pool_full_irq       = pf_q;
  assign message_end_irq     = me_q;
  assign frame_lost_irq      = lost_q;
  assign irq_pending         = busy_q;
  assign frame_byte_counter  = cnt_out_q;
  assign count_overflow_flag = ov_out_q;
  assign byte_count_low      = cnt_out_q[7:0];
  assign byte_count_high     = {ov_out_q, 3'h0, cnt_out_q[11:8]};

  // ****************************************
  // Assertions
  // ****************************************
  a_irq_after_idle: assert property (@(posedge clock) disable iff (!resetn) // RULE20
    (pf_q || me_q) |-> busy_q && !$past(busy_q))
    else $error("Block interrupt raised while a block was outstanding");

  a_no_irq_busy: assert property (@(posedge clock) disable iff (!resetn) // RULE13
    busy_q && !block_release_cmd |=> !(pf_q || me_q))
    else $error("Interrupt raised without a release");

  a_release_frees: assert property (@(posedge clock) disable iff (!resetn) // RULE13
    release_ && !rreset |=> rd_base_q - $past(rd_base_q) == (AW+1)'($past(blk_len_q)))
    else $error("Release did not free the block");

  a_reset_empty: assert property (@(posedge clock) disable iff (!resetn) // RULE14
    rreset |=> used == '0 && q_cnt_q == '0 && $stable(busy_q))
    else $error("Receiver reset left data or dropped a pending interrupt");

  a_fifo_bound: assert property (@(posedge clock) disable iff (!resetn) // RULE9
    used <= DEPTH_W && !(wr_stat && (free == '0 || q_full)))
    else $error("FIFO overfilled or no room for status");

  a_lost_drop: assert property (@(posedge clock) disable iff (!resetn) // RULE12
    frame_lost_irq |-> st_q == hdlc_rx_pkg::ST_DROP && ($past(free) == '0 || $past(q_full)))
    else $error("Frame lost without a full FIFO");

  a_read_cap: assert property (@(posedge clock) disable iff (!resetn) // RULE22
    rd_ofs_q <= blk_len_q)
    else $error("Read pointer ran past the block");

  a_thr_hold: assert property (@(posedge clock) disable iff (!resetn) // RULE18
    !block_release_cmd && !rreset |=> $stable(thr_code_q))
    else $error("Threshold changed without a command");

  a_count_ovf: assert property (@(posedge clock) disable iff (!resetn) // RULE15
    wr_data && !sof_go && !rreset && cnt_top |=> frame_ov_q)
    else $error("Length overflow not flagged");

endmodule : hdlc_rx_addr_filter_fifo

// ==== design/hdlc_rx_map.svh ====
// Constants of the HDLC receive path: codes, group values, sizes, status fields
`ifndef HDLC_RX_MAP_SVH
`define HDLC_RX_MAP_SVH

// ****************************************
// Address recognition
// ****************************************
`define HRX_CR_MASK     8'hFD
`define HRX_GROUP_HIGH  8'hFC
`define HRX_GROUP_LOW   8'hFF

// ****************************************
// Transfer mode codes
// ****************************************
`define HRX_MODE_ONE    3'h2
`define HRX_MODE_TWO    3'h3
`define HRX_MODE_EXT    3'h4
`define HRX_MODE_T2     3'h5
`define HRX_MODE_T0     3'h6
`define HRX_MODE_T1     3'h7

// ****************************************
// Block thresholds
// ****************************************
`define HRX_THR_32      2'h0
`define HRX_THR_16      2'h1
`define HRX_THR_8       2'h2
`define HRX_THR_RESET   2'h0
`define HRX_BLK_32      8'h20
`define HRX_BLK_16      8'h10
`define HRX_BLK_8       8'h08
`define HRX_BLK_4       8'h04

// ****************************************
// Byte counter and status byte fields
// ****************************************
`define HRX_CNT_MAX     12'hFFF
`define HRX_STAT_VFR    7
`define HRX_STAT_RDO    6
`define HRX_STAT_CRC    5
`define HRX_STAT_RAB    4
`define HRX_STAT_CR     1

`endif

// ==== design/hdlc_rx_pkg.sv ====
// Types shared by the HDLC receive path
package hdlc_rx_pkg;

  typedef struct packed {
    logic       sof;
    logic       eof;
    logic       valid;
    logic [7:0] data;
    logic       crc_ok;
    logic       abort;
  } rx_link_t;

  typedef struct packed {
    logic [7:0] high_a;
    logic [7:0] high_b;
    logic [7:0] low_a;
    logic [7:0] low_b;
  } addr_cfg_t;

  typedef struct packed {
    logic        is_end;
    logic [7:0]  len;
    logic [11:0] count;
    logic        ov;
  } rx_event_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ADDR = 4'h2,
    ST_DATA = 4'h4,
    ST_DROP = 4'h8
  } rx_state_t;

endpackage : hdlc_rx_pkg

// ==== dv/hdlc_rx_host_model.sv ====
// Host model: serves receive blocks and hands read bytes to the bench
module hdlc_rx_host_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Receiver events and data
  input  wire logic        pool_full_irq,
  input  wire logic        message_end_irq,
  input  wire logic [11:0] frame_byte_counter,
  input  wire logic [7:0]  receive_fifo,
  // Host pacing
  input  wire logic        stall,
  input  wire logic [7:0]  blk_size,
  output logic             host_rd,
  output logic             block_release_cmd,
  // Bytes read
  output logic             got_valid,
  output logic [7:0]       got_data
);
  timeunit 1ns;
  timeprecision 100ps;

  logic        owed;
  logic        is_end;
  logic [11:0] cnt;
  int          n;

  // Only one block is announced until it is released
  always @(negedge clock) begin
    if (resetn === 1'b1 && (pool_full_irq === 1'b1 || message_end_irq === 1'b1)) begin
      owed = 1'b1;
      is_end = message_end_irq;
      cnt = frame_byte_counter;
    end
  end

  initial begin
    owed = 1'b0;
    host_rd = 1'b0;
    block_release_cmd = 1'b0;
    got_valid = 1'b0;
    got_data = 8'h00;
    forever begin
      @(posedge clock);
      #1;
      got_valid = 1'b0;
      if (owed === 1'b1 && stall === 1'b0) begin
        n = (is_end && cnt % blk_size != 0) ? cnt % blk_size : blk_size;
        repeat ($urandom_range(3, 0)) @(posedge clock);
        #1;
        for (int i = 0; i < n; i++) begin
          host_rd = 1'b1;
          @(posedge clock);
          #1;
          host_rd = 1'b0;
          got_data = receive_fifo;
          got_valid = 1'b1;
          @(posedge clock);
          #1;
          got_valid = 1'b0;
        end
        owed = 1'b0;
        block_release_cmd = 1'b1;
        @(posedge clock);
        #1;
        block_release_cmd = 1'b0;
      end
    end
  end
endmodule : hdlc_rx_host_model

// ==== dv/hdlc_rx_addr_filter_fifo_bench.sv ====
// Self-checking bench of the HDLC receive path
`include "hdlc_rx_map.svh"
module hdlc_rx_addr_filter_fifo_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic clock, resetn, block_release_cmd, receiver_reset_cmd, host_rd;
  logic pool_full_irq, message_end_irq, frame_lost_irq, irq_pending;
  logic stall, got_valid;
  logic [2:0] transfer_mode_code;
  logic [1:0] rx_threshold_code;
  logic [7:0] receive_fifo, blk_size, got_data;
  logic [11:0] frame_byte_counter, ce;
  logic count_overflow_flag;
  logic [7:0] byte_count_low, byte_count_high, xb;
  hdlc_rx_pkg::rx_link_t link;
  hdlc_rx_pkg::addr_cfg_t addr_cfg;
  logic [7:0] exp_q[$];
  logic [11:0] cnt_q[$];
  int fails, checks_done, lost;

  hdlc_rx_addr_filter_fifo uut (
    .clock(clock), .resetn(resetn), .link(link),
    .transfer_mode_code(transfer_mode_code), .rx_threshold_code(rx_threshold_code),
    .addr_cfg(addr_cfg), .block_release_cmd(block_release_cmd),
    .receiver_reset_cmd(receiver_reset_cmd), .host_rd(host_rd),
    .receive_fifo(receive_fifo), .pool_full_irq(pool_full_irq),
    .message_end_irq(message_end_irq), .frame_lost_irq(frame_lost_irq),
    .irq_pending(irq_pending), .frame_byte_counter(frame_byte_counter),
    .count_overflow_flag(count_overflow_flag), .byte_count_low(byte_count_low),
    .byte_count_high(byte_count_high));

  hdlc_rx_host_model host (
    .clock(clock), .resetn(resetn), .pool_full_irq(pool_full_irq),
    .message_end_irq(message_end_irq), .frame_byte_counter(frame_byte_counter),
    .receive_fifo(receive_fifo), .stall(stall), .blk_size(blk_size),
    .host_rd(host_rd), .block_release_cmd(block_release_cmd),
    .got_valid(got_valid), .got_data(got_data));

  initial clock = 1'b0;
  always #5 clock = ~clock;

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk12(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk12

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  // Results taken off the queues as they appear
  always @(negedge clock) begin
    if (got_valid === 1'b1) begin
      chk8(got_data, exp_q.size() ? exp_q.pop_front() : ~got_data);
    end
    if (message_end_irq === 1'b1) begin
      ce = cnt_q.size() ? cnt_q.pop_front() : 12'hFFF;
      chk12(frame_byte_counter, ce);
      chk8(byte_count_low, ce[7:0]);
      chk8(byte_count_high, {4'h0, ce[11:8]});
      chk8(8'(count_overflow_flag), 8'h00);
    end
    if (frame_lost_irq === 1'b1) begin
      lost++;
    end
  end

  task automatic put(input logic s, input logic v, input logic e, input logic [7:0] d);
    @(posedge clock);
    #1;
    link = '{sof: s, eof: e, valid: v, data: d, crc_ok: e, abort: 1'b0};
  endtask : put

  // Address bytes first, then random data; kept frames are noted
  task automatic frame(input logic [7:0] a0, input logic [7:0] a1, input int na,
                       input int nd, input bit keep, input logic [7:0] stat);
    logic [7:0] b;
    put(1'b1, 1'b0, 1'b0, 8'h00);
    for (int i = 0; i < na + nd; i++) begin
      b = (i == 0 && na > 0) ? a0 : (i == 1 && na > 1) ? a1 : 8'($urandom()) & 8'hFD;
      put(1'b0, 1'b1, 1'b0, b);
      if (keep && i >= na) exp_q.push_back(b);
    end
    put(1'b0, 1'b0, 1'b1, 8'h00);
    put(1'b0, 1'b0, 1'b0, 8'h00);
    if (keep) begin
      exp_q.push_back(stat);
      cnt_q.push_back(12'(nd + 1));
    end
  endtask : frame

  task automatic drain;
    int n;
    n = 0;
    while ((exp_q.size() != 0 || cnt_q.size() != 0 || irq_pending !== 1'b0) && n < 3000) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n == 3000) begin
      chk8(8'h00, 8'h01);
      test_done();
    end
  endtask : drain

  task automatic set_mode(input logic [2:0] m, input logic [1:0] t, input logic [7:0] sz);
    drain();
    transfer_mode_code = m;
    rx_threshold_code = t;
    blk_size = sz;
    @(posedge clock);
    #1;
    receiver_reset_cmd = 1'b1;
    @(posedge clock);
    #1;
    receiver_reset_cmd = 1'b0;
  endtask : set_mode

  initial begin
    void'($urandom(32'h37c32b46));
    resetn = 1'b0;
    link = '0;
    transfer_mode_code = `HRX_MODE_TWO;
    rx_threshold_code = `HRX_THR_32;
    addr_cfg = '{high_a: 8'h10, high_b: 8'h24, low_a: 8'h33, low_b: 8'h47};
    receiver_reset_cmd = 1'b0;
    stall = 1'b0;
    blk_size = `HRX_BLK_32;
    fails = 0;
    checks_done = 0;
    lost = 0;
    repeat (2) @(posedge clock);
    #1;
    resetn = 1'b1;
    set_mode(`HRX_MODE_TWO, `HRX_THR_32, `HRX_BLK_32);
    frame(8'h10, 8'h47, 2, 3, 1'b1, 8'hA0);
    frame(8'h10, 8'h59, 2, 3, 1'b0, 8'h00);
    frame(8'hFE, 8'hFF, 2, 2, 1'b1, 8'hA2);
    frame(8'h26, 8'h33, 2, 1, 1'b1, 8'hA2);
    set_mode(`HRX_MODE_ONE, `HRX_THR_32, `HRX_BLK_32);
    frame(8'h24, 8'h00, 1, 4, 1'b1, 8'hA0);
    frame(8'h70, 8'h00, 1, 2, 1'b0, 8'h00);
    set_mode(`HRX_MODE_T0, `HRX_THR_32, `HRX_BLK_32);
    frame(8'h00, 8'h00, 0, 5, 1'b1, 8'hA0);
    set_mode(`HRX_MODE_T1, `HRX_THR_32, `HRX_BLK_32);
    frame(8'hFC, 8'h00, 1, 3, 1'b1, 8'hA0);
    frame(8'h90, 8'h00, 1, 3, 1'b0, 8'h00);
    set_mode(`HRX_MODE_T2, `HRX_THR_32, `HRX_BLK_32);
    frame(8'h3C, 8'h33, 2, 3, 1'b1, 8'hA0);
    frame(8'h3C, 8'hFF, 2, 2, 1'b1, 8'hA0);
    frame(8'h3C, 8'h5A, 2, 2, 1'b0, 8'h00);
    set_mode(`HRX_MODE_TWO, `HRX_THR_32, `HRX_BLK_32);
    frame(8'h10, 8'h33, 2, 40, 1'b1, 8'hA0);
    set_mode(`HRX_MODE_TWO, 2'h3, `HRX_BLK_4);
    frame(8'h10, 8'h33, 2, 10, 1'b1, 8'hA0);
    frame(8'h10, 8'h33, 2, 3, 1'b1, 8'hA0);
    rx_threshold_code = `HRX_THR_16;
    frame(8'h10, 8'h33, 2, 4, 1'b1, 8'hA0);
    drain();
    blk_size = `HRX_BLK_16;
    frame(8'h10, 8'h33, 2, 17, 1'b1, 8'hA0);
    set_mode(`HRX_MODE_EXT, 2'h3, `HRX_BLK_4);
    put(1'b1, 1'b0, 1'b0, 8'h00);
    for (int i = 0; i < 8; i++) begin
      xb = 8'($urandom());
      put(1'b0, 1'b1, 1'b0, xb);
      exp_q.push_back(xb);
    end
    put(1'b0, 1'b0, 1'b1, 8'h00);
    put(1'b0, 1'b0, 1'b0, 8'h00);
    set_mode(`HRX_MODE_TWO, `HRX_THR_32, `HRX_BLK_32);
    stall = 1'b1;
    repeat (8) frame(8'h10, 8'h33, 2, 7, 1'b1, 8'hA0);
    frame(8'h10, 8'h33, 2, 3, 1'b0, 8'h00);
    stall = 1'b0;
    drain();
    chk8(8'(lost), 8'h01);
    test_done();
  end
endmodule : hdlc_rx_addr_filter_fifo_bench
